/* File: rtl/scc_host_port.sv */
/*
 * Multiplexed host bus port, interrupt daisy chain and per-channel modem pin logic.
 * Assumes the strobe, select, chain, modem and clock pin inputs are asynchronous and are synchronised here to clk.
 */
`timescale 1ns/1ps
`default_nettype none
module scc_host_port (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] muxedBusIn,
    output logic [7:0] muxedBusOut,
    output logic muxedBusOe_n,
    input wire logic addressStrobe_n,
    input wire logic dataStrobe_n,
    input wire logic chipSelectLow_n,
    input wire logic chipSelectHigh,
    input wire logic readWriteSelect,
    input wire logic irqAcknowledgeIn_n,
    input wire logic chainEnableIn,
    output logic chainEnableOut,
    output logic irqOut,
    output logic irqOutOe_n,
    output logic strobeReset,
    input wire logic [1:0] clearToSend_n,
    input wire logic [1:0] carrierDetect_n,
    input wire logic [1:0] framingPinIn_n,
    output logic [1:0] framingPinOut,
    output logic [1:0] framingPinOe_n,
    input wire logic [1:0] rxTxClockPin,
    input wire logic [1:0] txEmpty,
    input wire logic [1:0] dmaRequest,
    input wire logic [1:0] waitRequest,
    input wire logic [1:0] irqUnderService,
    input wire logic [3:0] clockUse,
    input wire logic [3:0] clockRate,
    output logic [1:0] requestToSend_n,
    output logic [1:0] terminalReady_n,
    output logic [1:0] waitDma,
    output logic [1:0] waitDmaOe_n,
    output logic [1:0] receiverEnable,
    output logic [1:0] rxClock,
    output logic [1:0] txClock,
    output logic [1:0] baudClock,
    output logic [1:0] pllClock,
    output logic [1:0] charAssemblyStart,
    output logic [3:0] rateCode
);
    ////////////////////////////////////////////////////////////////////////////////
    // Synchronisers; only the second stage is ever looked at.
    localparam int NSYNC = 15;
    // Synchronisers reset to the idle pin levels, so no false strobe edge or strobe reset follows reset.
    localparam logic [NSYNC-1:0] SYNC_IDLE = 15'h1FF3;
    logic [NSYNC-1:0] rawIn;
    logic [NSYNC-1:0] syncA;
    logic [NSYNC-1:0] syncB;
    logic [NSYNC-1:0] next_syncA;
    logic [NSYNC-1:0] next_syncB;
    logic [7:0] busIn;

    always_comb begin
        rawIn = {rxTxClockPin, framingPinIn_n, carrierDetect_n, clearToSend_n, addressStrobe_n,
                 dataStrobe_n, chipSelectLow_n, chipSelectHigh, readWriteSelect, irqAcknowledgeIn_n,
                 chainEnableIn};
        next_syncA = rawIn;
        next_syncB = syncA;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            syncA <= SYNC_IDLE;
            syncB <= SYNC_IDLE;
            busIn <= scc_pins_pkg::DATA_RESET;
        end else begin
            syncA <= next_syncA;
            syncB <= next_syncB;
            busIn <= muxedBusIn;
        end
    end

    logic [1:0] sClk, sFrame, sDcd, sCts;
    logic sAs, sDs, sCs0, sCs1, sRw, sAck, sIei;
    always_comb begin
        {sClk, sFrame, sDcd, sCts, sAs, sDs, sCs0, sCs1, sRw, sAck, sIei} = syncB;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Host bus sequencer. The data byte is taken one clock after its strobe, since the
    // muxed lines are flopped once while the strobes pass through two stages.
    scc_pins_pkg::bus_state_t state, next_state;
    logic prevAs, next_prevAs;
    logic [7:0] addr, next_addr;
    logic csLatched, next_csLatched;
    logic ackLatched, next_ackLatched;
    logic [7:0] busOut, next_busOut;
    logic busOe_n, next_busOe_n;
    logic resetPulse, next_resetPulse;
    logic memWrite;
    logic [7:0] memRead;
    logic [7:0] ctrl [2];
    logic [7:0] next_ctrl [2];
    logic [7:0] vector, next_vector;
    logic [1:0] change, next_change;
    logic [1:0] hunt, next_hunt;
    logic irqPending;

    function automatic logic [scc_pins_pkg::REG_IDX_W-1:0] regIdx(input logic [7:0] a);
        regIdx = a[scc_pins_pkg::REG_IDX_W-1:0];
    endfunction : regIdx

    always_comb begin
        next_state = state;
        next_prevAs = sAs;
        next_addr = addr;
        next_csLatched = csLatched;
        next_ackLatched = ackLatched;
        next_busOut = busOut;
        next_busOe_n = 1'b1;
        next_resetPulse = !sAs && !sDs;
        memWrite = 1'b0;
        next_ctrl = ctrl;
        next_vector = vector;
        if (!prevAs && sAs) begin
            next_addr = busIn;
            next_csLatched = !sCs0;
            next_ackLatched = !sAck;
            next_state = scc_pins_pkg::BUS_ADDR;
        end
        case (state)
            scc_pins_pkg::BUS_IDLE: begin
            end
            scc_pins_pkg::BUS_ADDR: begin
                if (!sDs && sAs) begin
                    if (ackLatched) begin
                        next_state = scc_pins_pkg::BUS_ACK;
                    end else if (csLatched && sCs1) begin
                        next_state = scc_pins_pkg::BUS_DATA;
                    end else begin
                        next_state = scc_pins_pkg::BUS_IDLE;
                    end
                end
            end
            scc_pins_pkg::BUS_DATA: begin
                if (sDs || !sCs1) begin
                    next_state = scc_pins_pkg::BUS_IDLE;
                end else if (sRw) begin
                    next_busOut = memRead;
                    if (regIdx(addr) == scc_pins_pkg::STATUS_IDX) begin
                        next_busOut = scc_pins_pkg::DATA_RESET;
                        next_busOut[scc_pins_pkg::S_CTS] = !sCts[addr[4]];
                        next_busOut[scc_pins_pkg::S_DCD] = !sDcd[addr[4]];
                        next_busOut[scc_pins_pkg::S_HUNT] = hunt[addr[4]];
                        next_busOut[scc_pins_pkg::S_CHANGE] = change[addr[4]];
                    end
                    next_busOe_n = 1'b0;
                end else begin
                    memWrite = 1'b1;
                    if (regIdx(addr) == scc_pins_pkg::CTRL_IDX) begin
                        next_ctrl[addr[4]] = busIn;
                    end
                    if (regIdx(addr) == scc_pins_pkg::VECTOR_IDX) begin
                        next_vector = busIn;
                    end
                end
            end
            scc_pins_pkg::BUS_ACK: begin
                if (sDs) begin
                    next_state = scc_pins_pkg::BUS_IDLE;
                end else if (sIei && irqPending) begin
                    next_busOut = vector;
                    next_busOe_n = 1'b0;
                end
            end
            default: begin
                next_state = scc_pins_pkg::BUS_IDLE;
            end
        endcase
        if (next_resetPulse) begin
            next_state = scc_pins_pkg::BUS_IDLE;
            next_busOe_n = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= scc_pins_pkg::BUS_IDLE;
            prevAs <= 1'b1;
            addr <= scc_pins_pkg::DATA_RESET;
            csLatched <= 1'b0;
            ackLatched <= 1'b0;
            busOut <= scc_pins_pkg::DATA_RESET;
            busOe_n <= 1'b1;
            resetPulse <= 1'b0;
            ctrl[0] <= scc_pins_pkg::DATA_RESET;
            ctrl[1] <= scc_pins_pkg::DATA_RESET;
            vector <= scc_pins_pkg::VECTOR_RESET;
        end else begin
            state <= next_state;
            prevAs <= next_prevAs;
            addr <= next_addr;
            csLatched <= next_csLatched;
            ackLatched <= next_ackLatched;
            busOut <= next_busOut;
            busOe_n <= next_busOe_n;
            resetPulse <= next_resetPulse;
            ctrl <= resetPulse ? '{scc_pins_pkg::DATA_RESET, scc_pins_pkg::DATA_RESET} : next_ctrl;
            vector <= next_vector;
        end
    end

    scc_reg_mem u_mem (
        .clk(clk),
        .rst(rst),
        .writeEn(memWrite),
        .writeIdx(regIdx(addr)),
        .writeData(busIn),
        .readIdx(regIdx(addr)),
        .readData(memRead)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Modem pins, change detection and the interrupt chain.
    logic [3:0] prevModem, next_prevModem;
    logic [1:0] prevFrame, next_prevFrame;
    logic [1:0] prevClk, next_prevClk;
    logic [1:0] rtsHold, next_rtsHold;
    logic [1:0] lastRise, next_lastRise;
    logic [1:0] next_rts_n, next_tr_n, next_wait, next_waitOe_n, next_rxEn, next_start;
    logic [1:0] next_rxC, next_txC, next_bdC, next_plC, next_frOe_n;
    logic next_ieo, next_irqOe_n;

    always_comb begin
        irqPending = |change;
        next_prevModem = {sDcd, sCts};
        next_prevFrame = sFrame;
        next_prevClk = sClk;
        next_change = change;
        next_hunt = hunt;
        next_rtsHold = rtsHold;
        next_lastRise = lastRise;
        for (int c = 0; c < scc_pins_pkg::NUM_CHANNELS; c++) begin
            logic async, auto, xtal;
            async = ctrl[c][scc_pins_pkg::B_ASYNC];
            auto = ctrl[c][scc_pins_pkg::B_AUTO_EN];
            xtal = ctrl[c][scc_pins_pkg::B_XTAL];
            // The set wins over a clear made by reading the status register.
            // The flag is cleared as the read ends, so the byte on the bus still shows it.
            if (state == scc_pins_pkg::BUS_DATA && sRw && sDs && regIdx(addr) == scc_pins_pkg::STATUS_IDX
                && addr[4] == c[0]) begin
                next_change[c] = 1'b0;
            end
            if (sCts[c] != prevModem[c] || sDcd[c] != prevModem[c+2]) begin
                next_change[c] = 1'b1;
            end
            if (async && !xtal && sFrame[c] != prevFrame[c]) begin
                next_hunt[c] = !sFrame[c];
            end
            if (ctrl[c][scc_pins_pkg::B_RTS]) begin
                next_rtsHold[c] = 1'b1;
            end else if (!(async && auto) || txEmpty[c]) begin
                next_rtsHold[c] = 1'b0;
            end
            next_rts_n[c] = !next_rtsHold[c];
            next_tr_n[c] = ctrl[c][scc_pins_pkg::B_TR_IS_DMA] ? !dmaRequest[c]
                                                              : !ctrl[c][scc_pins_pkg::B_TERM_READY];
            if (ctrl[c][scc_pins_pkg::B_WAIT_IS_DMA]) begin
                next_wait[c] = dmaRequest[c];
                next_waitOe_n[c] = 1'b0;
            end else begin
                next_wait[c] = 1'b0;
                next_waitOe_n[c] = !waitRequest[c];
            end
            next_rxEn[c] = auto ? !sDcd[c] : 1'b1;
            next_start[c] = 1'b0;
            if (sClk[c] && !prevClk[c]) begin
                next_lastRise[c] = 1'b1;
            end
            if (ctrl[c][scc_pins_pkg::B_EXT_SYNC] && !xtal && prevFrame[c] && !sFrame[c]) begin
                next_start[c] = lastRise[c];
                next_lastRise[c] = 1'b0;
            end
            next_rxC[c] = clockUse[2*c +: 2] == scc_pins_pkg::CLK_AS_RX && !xtal && sClk[c];
            next_txC[c] = clockUse[2*c +: 2] == scc_pins_pkg::CLK_AS_TX && !xtal && sClk[c];
            next_bdC[c] = clockUse[2*c +: 2] == scc_pins_pkg::CLK_AS_BAUD && sClk[c];
            next_plC[c] = clockUse[2*c +: 2] == scc_pins_pkg::CLK_AS_PLL && sClk[c];
            next_frOe_n[c] = 1'b1;
        end
        next_ieo = sIei && !irqPending && !(|irqUnderService);
        next_irqOe_n = !irqPending;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            prevModem <= '1;
            prevFrame <= '1;
            prevClk <= '0;
            change <= '0;
            hunt <= '0;
            rtsHold <= '0;
            lastRise <= '0;
            requestToSend_n <= '1;
            terminalReady_n <= '1;
            waitDma <= '0;
            waitDmaOe_n <= '1;
            receiverEnable <= '0;
            charAssemblyStart <= '0;
            rxClock <= '0;
            txClock <= '0;
            baudClock <= '0;
            pllClock <= '0;
            framingPinOe_n <= '1;
            chainEnableOut <= 1'b0;
            irqOutOe_n <= 1'b1;
        end else begin
            prevModem <= next_prevModem;
            prevFrame <= next_prevFrame;
            prevClk <= next_prevClk;
            change <= next_change;
            hunt <= next_hunt;
            rtsHold <= next_rtsHold;
            lastRise <= next_lastRise;
            requestToSend_n <= next_rts_n;
            terminalReady_n <= next_tr_n;
            waitDma <= next_wait;
            waitDmaOe_n <= next_waitOe_n;
            receiverEnable <= next_rxEn;
            charAssemblyStart <= next_start;
            rxClock <= next_rxC;
            txClock <= next_txC;
            baudClock <= next_bdC;
            pllClock <= next_plC;
            framingPinOe_n <= next_frOe_n;
            chainEnableOut <= next_ieo;
            irqOutOe_n <= next_irqOe_n;
        end
    end

    // Rate code is passed on registered; all four multiples are legal in async mode.
    always_ff @(posedge clk) begin
        if (rst) begin
            rateCode <= {scc_pins_pkg::CLK_X1, scc_pins_pkg::CLK_X1};
            muxedBusOut <= scc_pins_pkg::DATA_RESET;
            muxedBusOe_n <= 1'b1;
            irqOut <= 1'b0;
            framingPinOut <= '0;
            strobeReset <= 1'b0;
        end else begin
            rateCode <= clockRate;
            muxedBusOut <= busOut;
            muxedBusOe_n <= busOe_n;
            irqOut <= 1'b0;
            framingPinOut <= '0;
            strobeReset <= resetPulse;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    a_oe_only_data: assert property (@(posedge clk) disable iff (rst)
        !muxedBusOe_n |-> $past(state, 2) inside {scc_pins_pkg::BUS_DATA, scc_pins_pkg::BUS_ACK})
        else $error("bus driven outside data phase");
    a_irq_follows: assert property (@(posedge clk) disable iff (rst)
        irqPending |=> !irqOutOe_n) else $error("interrupt not driven");
    a_chain_block: assert property (@(posedge clk) disable iff (rst)
        $past(irqPending) |-> !chainEnableOut) else $error("chain not blocked");
    a_strobe_reset: assert property (@(posedge clk) disable iff (rst)
        (!sAs && !sDs) |-> ##2 strobeReset) else $error("strobe reset missed");
    a_rts_sync: assert property (@(posedge clk) disable iff (rst)
        (!ctrl[0][scc_pins_pkg::B_ASYNC] && $stable(ctrl[0])) |=> requestToSend_n[0] == !$past(ctrl[0][0]))
        else $error("request-to-send not tracking");
    a_rts_hold: assert property (@(posedge clk) disable iff (rst)
        (rtsHold[0] && ctrl[0][scc_pins_pkg::B_ASYNC] && ctrl[0][scc_pins_pkg::B_AUTO_EN] && !txEmpty[0])
        |=> rtsHold[0]) else $error("request-to-send released early");
    a_change_set: assert property (@(posedge clk) disable iff (rst)
        (sCts[0] != prevModem[0]) |=> change[0]) else $error("modem change lost");
    a_wait_reset: assert property (@(posedge clk) disable iff (rst)
        !ctrl[1][scc_pins_pkg::B_WAIT_IS_DMA] |=> !waitDma[1]) else $error("wait pin driven high");
endmodule : scc_host_port
`default_nettype wire

/* File: common/scc_pins_pkg.sv */
/*
 * Constants and enumerations shared by the serial controller host port and its modem pin logic.
 * Assumes a single 100 MHz clock and synchronous active-high reset in every user.
 */
package scc_pins_pkg;
    localparam int CLK_MHZ = 100;
    localparam int SYNC_STAGES = 2;
    localparam int NUM_CHANNELS = 2;
    localparam int REG_ADDR_W = 8;
    localparam int REG_DEPTH = 16;
    localparam int REG_IDX_W = 4;
    localparam logic [7:0] VECTOR_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    // Control register layout (index CTRL_IDX): one byte of bits per channel.
    localparam logic [3:0] CTRL_IDX = 4'h0;
    localparam logic [3:0] VECTOR_IDX = 4'h2;
    localparam logic [3:0] STATUS_IDX = 4'h1;
    localparam int B_RTS = 0;
    localparam int B_TERM_READY = 1;
    localparam int B_AUTO_EN = 2;
    localparam int B_ASYNC = 3;
    localparam int B_EXT_SYNC = 4;
    localparam int B_XTAL = 5;
    localparam int B_WAIT_IS_DMA = 6;
    localparam int B_TR_IS_DMA = 7;
    // Status layout: bit 0 clear-to-send, 1 carrier-detect, 2 sync/hunt, 3 change seen.
    localparam int S_CTS = 0;
    localparam int S_DCD = 1;
    localparam int S_HUNT = 2;
    localparam int S_CHANGE = 3;
    localparam logic [1:0] CLK_X1 = 2'h0;
    localparam logic [1:0] CLK_X16 = 2'h1;
    localparam logic [1:0] CLK_X32 = 2'h2;
    localparam logic [1:0] CLK_X64 = 2'h3;
    typedef enum logic [1:0] {CLK_AS_RX, CLK_AS_TX, CLK_AS_BAUD, CLK_AS_PLL} clk_use_t;
    typedef enum {BUS_IDLE, BUS_ADDR, BUS_DATA, BUS_ACK} bus_state_t;
endpackage : scc_pins_pkg

/* File: rtl/scc_reg_mem.sv */
/*
 * Small register memory for the host port; the read word comes out of a flip-flop.
 * Assumes the caller gates writes to a selected data phase.
 */
`timescale 1ns/1ps
`default_nettype none
module scc_reg_mem (
    input wire logic clk,
    input wire logic rst,
    input wire logic writeEn,
    input wire logic [scc_pins_pkg::REG_IDX_W-1:0] writeIdx,
    input wire logic [7:0] writeData,
    input wire logic [scc_pins_pkg::REG_IDX_W-1:0] readIdx,
    output logic [7:0] readData
);
    logic [7:0] mem [scc_pins_pkg::REG_DEPTH];
    logic [7:0] next_readData;

    always_comb begin
        next_readData = mem[readIdx];
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            readData <= scc_pins_pkg::DATA_RESET;
            for (int i = 0; i < scc_pins_pkg::REG_DEPTH; i++) begin
                mem[i] <= scc_pins_pkg::DATA_RESET;
            end
        end else begin
            readData <= next_readData;
            if (writeEn) begin
                mem[writeIdx] <= writeData;
            end
        end
    end
endmodule : scc_reg_mem
`default_nettype wire

/* File: verif/host_bus_model.sv */
/*
 * Host processor model that runs cycles on the multiplexed bus of the host port.
 * Assumes a 10 ns clk and a registered drive and drive enable from the host port.
 */
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
    input wire logic clk,
    input wire logic [7:0] muxedBusOut,
    input wire logic muxedBusOe_n,
    output logic [7:0] busLevel,
    output var logic addressStrobe_n,
    output var logic dataStrobe_n,
    output var logic chipSelectLow_n,
    output var logic chipSelectHigh,
    output var logic readWriteSelect,
    output var logic irqAcknowledgeIn_n
);
    logic [7:0] hostData;
    logic [7:0] lastLevel;
    logic hostOe;
    // A bus nobody drives shows the inverse of its last level, so a stale byte never passes.
    assign busLevel = !muxedBusOe_n ? muxedBusOut : hostOe ? hostData : ~lastLevel;
    always @(posedge clk) begin
        lastLevel <= busLevel;
    end
    initial begin
        {hostOe, hostData, lastLevel} = 17'h0;
        {addressStrobe_n, dataStrobe_n, chipSelectLow_n, irqAcknowledgeIn_n} = 4'hF;
        {chipSelectHigh, readWriteSelect} = 2'h0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic cycle(input logic [7:0] a, input logic [7:0] d, input logic rd, input logic ack,
        input logic csl, input logic csh, output logic [7:0] got, output logic oe);
        @(posedge clk);
        #1 chipSelectHigh = csh;
        chipSelectLow_n = !csl;
        irqAcknowledgeIn_n = !ack;
        readWriteSelect = rd;
        hostData = a;
        hostOe = 1'b1;
        addressStrobe_n = 1'b0;
        repeat (4) @(posedge clk);
        #1 addressStrobe_n = 1'b1;
        repeat (4) @(posedge clk);
        #1 hostOe = !rd;
        hostData = d;
        dataStrobe_n = 1'b0;
        repeat (8) @(posedge clk);
        #1 got = busLevel;
        oe = muxedBusOe_n;
        dataStrobe_n = 1'b1;
        repeat (4) @(posedge clk);
        #1 {hostOe, chipSelectHigh} = 2'h0;
        {chipSelectLow_n, irqAcknowledgeIn_n} = 2'h3;
    endtask : cycle
    task automatic bothLow();
        @(posedge clk);
        #1 {addressStrobe_n, dataStrobe_n} = 2'h0;
        repeat (4) @(posedge clk);
        #1 {addressStrobe_n, dataStrobe_n} = 2'h3;
    endtask : bothLow
endmodule : host_bus_model
`default_nettype wire

/* File: verif/tb.sv */
/*
 * Self-checking bench for the host port: bus cycles, daisy chain, modem and clock pins.
 * Assumes the host bus model beside it and a 100 MHz clk with synchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk, rst, chainEnableIn, chipSelectLow_n, chipSelectHigh, readWriteSelect, oe;
    logic addressStrobe_n, dataStrobe_n, irqAcknowledgeIn_n, muxedBusOe_n, chainEnableOut;
    logic irqOutOe_n, strobeReset;
    logic [7:0] muxedBusIn, muxedBusOut, got;
    logic [1:0] clearToSend_n, carrierDetect_n, framingPinIn_n, rxTxClockPin, txEmpty;
    logic [1:0] dmaRequest, waitRequest, irqUnderService, requestToSend_n, terminalReady_n;
    logic [1:0] waitDmaOe_n, receiverEnable, rxClock, txClock, baudClock, pllClock, charAssemblyStart;
    logic [3:0] clockUse, clockRate, rateCode;
    int nErrors = 0;
    int checksDone = 0;
    scc_host_port scc_host_port_i (.clk, .rst, .muxedBusIn, .muxedBusOut, .muxedBusOe_n,
        .addressStrobe_n, .dataStrobe_n, .chipSelectLow_n, .chipSelectHigh, .readWriteSelect,
        .irqAcknowledgeIn_n, .chainEnableIn, .chainEnableOut, .irqOut(), .irqOutOe_n,
        .strobeReset, .clearToSend_n, .carrierDetect_n, .framingPinIn_n, .framingPinOut(),
        .framingPinOe_n(), .rxTxClockPin, .txEmpty, .dmaRequest, .waitRequest,
        .irqUnderService, .clockUse, .clockRate, .requestToSend_n, .terminalReady_n,
        .waitDma(), .waitDmaOe_n, .receiverEnable, .rxClock, .txClock, .baudClock, .pllClock,
        .charAssemblyStart, .rateCode);
    host_bus_model host_bus_model_i (.clk, .muxedBusOut, .muxedBusOe_n,
        .busLevel(muxedBusIn), .addressStrobe_n, .dataStrobe_n, .chipSelectLow_n,
        .chipSelectHigh, .readWriteSelect, .irqAcknowledgeIn_n);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checksDone++;
        if (seen !== exp) begin
            nErrors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic completeRun();
        if (nErrors == 0 && checksDone > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : completeRun
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host_bus_model_i.cycle(a, d, 1'b0, 1'b0, 1'b1, 1'b1, got, oe);
        repeat (6) @(posedge clk);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        host_bus_model_i.cycle(a, 8'h00, 1'b1, 1'b0, 1'b1, 1'b1, got, oe);
    endtask : rd
    task automatic ackCycle(input logic [7:0] vec, input logic drives, input logic chain);
        fork
            host_bus_model_i.cycle(8'h00, 8'h00, 1'b1, 1'b1, 1'b1, 1'b1, got, oe);
            begin
                repeat (14) @(posedge clk);
                #2 check({7'h0, chainEnableOut}, {7'h0, chain});
            end
        join
        check({7'h0, oe}, {7'h0, !drives});
        if (drives) check(got, vec);
    endtask : ackCycle
    ////////////////////////////////////////////////////////////////////////////////
    task automatic testRts();
        wr(8'h00, 8'h03);
        check({6'h0, requestToSend_n}, 8'h02);
        check({6'h0, terminalReady_n}, 8'h02);
        rd(8'h00);
        check(got, 8'h03);
        check({7'h0, oe}, 8'h00);
        repeat (6) @(posedge clk);
        check({7'h0, muxedBusOe_n}, 8'h01);
        wr(8'h10, 8'h01);
        check({6'h0, requestToSend_n}, 8'h00);
        wr(8'h00, 8'h00);
        wr(8'h10, 8'h00);
        check({4'h0, requestToSend_n, terminalReady_n}, 8'h0F);
        #1 dmaRequest = 2'h2;
        wr(8'h10, 8'hC0);
        check({6'h0, terminalReady_n}, 8'h01);
        check({6'h0, waitDmaOe_n}, 8'h01);
        wr(8'h10, 8'h00);
        #1 dmaRequest = 2'h0;
    endtask : testRts
    task automatic testSelects();
        host_bus_model_i.cycle(8'h00, 8'h03, 1'b0, 1'b0, 1'b0, 1'b1, got, oe);
        host_bus_model_i.cycle(8'h00, 8'h03, 1'b0, 1'b0, 1'b1, 1'b0, got, oe);
        host_bus_model_i.cycle(8'h00, 8'h00, 1'b1, 1'b0, 1'b0, 1'b1, got, oe);
        check({7'h0, oe}, 8'h01);
        rd(8'h00);
        check(got, 8'h00);
    endtask : testSelects
    task automatic testAutoRts();
        wr(8'h00, 8'h0D);
        wr(8'h00, 8'h0C);
        check({7'h0, requestToSend_n[0]}, 8'h00);
        #1 txEmpty = 2'h1;
        repeat (6) @(posedge clk);
        check({7'h0, requestToSend_n[0]}, 8'h01);
        #1 carrierDetect_n = 2'h2;
        repeat (6) @(posedge clk);
        check({6'h0, receiverEnable}, 8'h03);
        rd(8'h01);
        #1 carrierDetect_n = 2'h3;
        wr(8'h00, 8'h00);
        rd(8'h01);
    endtask : testAutoRts
    task automatic testModem();
        for (int e = 0; e < 2; e++) begin
            #1 clearToSend_n[0] = e[0];
            repeat (6) @(posedge clk);
            check({7'h0, irqOutOe_n}, 8'h00);
            rd(8'h01);
            check({7'h0, got[3]}, 8'h01);
            repeat (6) @(posedge clk);
            check({7'h0, irqOutOe_n}, 8'h01);
        end
    endtask : testModem
    task automatic testVector();
        wr(8'h02, 8'h5A);
        #1 clearToSend_n[1] = 1'b0;
        repeat (6) @(posedge clk);
        ackCycle(8'h5A, 1'b1, 1'b0);
        #1 chainEnableIn = 1'b0;
        ackCycle(8'h5A, 1'b0, 1'b0);
        #1 chainEnableIn = 1'b1;
        rd(8'h11);
        repeat (6) @(posedge clk);
        ackCycle(8'h5A, 1'b0, 1'b1);
        #1 irqUnderService = 2'h2;
        ackCycle(8'h5A, 1'b0, 1'b0);
        #1 irqUnderService = 2'h0;
    endtask : testVector
    task automatic testClocks();
        for (int u = 0; u < 4; u++) begin
            #1 clockUse = u[3:0];
            clockRate = u[3:0];
            rxTxClockPin = 2'h1;
            repeat (6) @(posedge clk);
            check({4'h0, pllClock[0], baudClock[0], txClock[0], rxClock[0]}, 8'h01 << u);
            check({4'h0, rateCode}, {4'h0, u[3:0]});
        end
    endtask : testClocks
    task automatic testStrobeReset();
        wr(8'h00, 8'h01);
        host_bus_model_i.bothLow();
        check({7'h0, strobeReset}, 8'h01);
        repeat (6) @(posedge clk);
        check({6'h0, requestToSend_n}, 8'h03);
    endtask : testStrobeReset
    task automatic testExtSync();
        wr(8'h00, 8'h10);
        for (int k = 0; k < 4; k++) begin
            #1 rxTxClockPin = {1'b0, k[0]};
            repeat (4) @(posedge clk);
        end
        #1 framingPinIn_n = 2'h2;
        repeat (3) @(posedge clk);
        #1 check({6'h0, charAssemblyStart}, 8'h01);
        @(posedge clk);
        #1 check({6'h0, charAssemblyStart}, 8'h00);
        framingPinIn_n = 2'h3;
    endtask : testExtSync
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst, chainEnableIn, waitRequest} = 4'hF;
        {clearToSend_n, carrierDetect_n, framingPinIn_n} = 6'h3F;
        {rxTxClockPin, txEmpty, dmaRequest, irqUnderService, clockUse, clockRate} = 16'h0;
        repeat (6) @(posedge clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge clk);
        check({6'h0, waitDmaOe_n}, 8'h00);
        check({7'h0, muxedBusOe_n}, 8'h01);
        #1 waitRequest = 2'h0;
        testRts();
        testSelects();
        testAutoRts();
        testModem();
        testVector();
        testClocks();
        testStrobeReset();
        testExtSync();
        completeRun();
    end
    initial begin
        #100000;
        nErrors++;
        completeRun();
    end
endmodule : tb
`default_nettype wire
